// ---- rtl/rpw_defines.svh ----
`ifndef RPW_DEFINES_SVH
`define RPW_DEFINES_SVH

// Window geometry, byte offsets inside the 16 KB protection window
`define RPW_ADDR_W 14
`define RPW_RSVD_BASE 14'h1800
`define RPW_MIRROR_BASE 14'h2000
`define RPW_MIRROR_END 14'h37ff
`define RPW_LOCK_BASE 14'h3800
`define RPW_LOCK_END 14'h3dff
`define RPW_CFG_BASE 14'h3e00
`define RPW_GCR_OFS 14'h3ffc

// Lock store size: one 4-bit lock register per pass-through word
`define RPW_LOCK_REGS 1536
`define RPW_LOCK_WORDS 384

// Field positions
`define RPW_GCR_HLB_BIT 31
`define RPW_GCR_UAA_BIT 0
`define RPW_SLB_LSB 0
`define RPW_WE_LSB 4

// Reset values
`define RPW_HLB_RST 1'b0
`define RPW_UAA_RST 1'b0
`define RPW_SLB_RST 4'h0

`endif

// ---- rtl/rpw_pkg.sv ----
`include "rpw_defines.svh"

package rpw_pkg;

    // Transaction sequencer, Gray coded along idle-check-wait-resp
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CHECK = 2'b01,
        ST_WAIT = 2'b11,
        ST_RESP = 2'b10
    } rpw_state_e;

    // Protection unit of one protected-module word
    typedef enum logic [1:0] {
        PS_NONE = 2'h0,
        PS_8 = 2'h1,
        PS_16 = 2'h2,
        PS_32 = 2'h3
    } rpw_psize_e;

    // Window areas
    typedef enum logic [2:0] {
        AR_PASS = 3'h0,
        AR_RSVD = 3'h1,
        AR_MIRROR = 3'h2,
        AR_LOCK = 3'h3,
        AR_CFG = 3'h4
    } rpw_area_e;

    // Protection map of the protected module, indexed by lock register
    function automatic rpw_psize_e prot_size(input logic [10:0] reg_idx);
        case (reg_idx[1:0])
            2'h0: prot_size = PS_32;
            2'h1: prot_size = PS_16;
            2'h2: prot_size = PS_8;
            default: prot_size = PS_NONE;
        endcase
    endfunction

endpackage

// ---- rtl/rpw_lock_if.sv ----
`timescale 1ns/100ps

// Lock store access between the sequencer and the lock array
interface rpw_lock_if;
    logic [10:0] chk_reg;
    logic [3:0] chk_bits;
    logic [8:0] rd_word;
    logic [15:0] rd_bits;
    logic wr_en;
    logic [8:0] wr_word;
    logic [15:0] wr_we;
    logic [15:0] wr_val;

    modport store (
        input chk_reg,
        input rd_word,
        input wr_en,
        input wr_word,
        input wr_we,
        input wr_val,
        output chk_bits,
        output rd_bits
    );

    modport ctrl (
        output chk_reg,
        output rd_word,
        output wr_en,
        output wr_word,
        output wr_we,
        output wr_val,
        input chk_bits,
        input rd_bits
    );
endinterface

// ---- rtl/rpw_lock_store.sv ----
`timescale 1ns/100ps
`include "rpw_defines.svh"

module rpw_lock_store (
    input wire logic clk,
    input wire logic rst_n,
    rpw_lock_if.store lk
);

    logic [3:0] byte_lock_bit [0:`RPW_LOCK_REGS-1];

    // Lock bits: cleared by reset, bitwise masked update
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int i = 0; i < `RPW_LOCK_REGS; i++) begin
                byte_lock_bit[i] <= `RPW_SLB_RST;
            end
        end else if (lk.wr_en) begin
            for (int l = 0; l < 4; l++) begin
                for (int m = 0; m < 4; m++) begin
                    if (lk.wr_we[4*l+m]) begin
                        byte_lock_bit[{lk.wr_word, 2'(l)}][m] <= lk.wr_val[4*l+m];
                    end
                end
            end
        end
    end

    // Lock bits of one protected word, for the write check
    assign lk.chk_bits = byte_lock_bit[lk.chk_reg];

    // Four lock registers of one lock-area word, for reads
    always_comb begin
        lk.rd_bits = 16'h0;
        for (int l = 0; l < 4; l++) begin
            lk.rd_bits[4*l +: 4] = byte_lock_bit[{lk.rd_word, 2'(l)}];
        end
    end

endmodule

// ---- rtl/rpw_top.sv ----
`timescale 1ns/100ps
`include "rpw_defines.svh"

// Functional notes
// - Lowest 6 KB passes straight to the module, reads and writes, after checks.
// - Reserved 2 KB at 0x1800 is forwarded; the module decides the answer.
// - Offset 0x2000 plus X reaches module register X.
// - Mirror write sets lock bits of written protectable bytes with the update.
// - Unprotected registers behave identically through the mirror, no lock change.
// - Lock bits exist only for protectable bytes; one bit per byte.
// - Lock registers at 0x3800-0x3DFF; bit m of register n guards byte 4n+m.
// - Lock bit changes only where the write-enable bit of its unit's lowest bit is one.
// - Lock bit one makes its byte read-only; zero leaves it writable.
// - Write touching any locked byte errors and writes nothing.
// - Hard lock blocks all lock changes until system reset.
// - Configuration word at 0x3FFC; 0x3E00-0x3FFB reserved.
// - Hard lock cannot be cleared by software; while set locks are frozen.
// - User access off: non-supervisor writes dropped with transfer error.
// - Supervisor check adds to the module's own restrictions.
// - User access on: no added mode restriction on module accesses; lock and configuration writes stay supervisor-only.
// - Unimplemented words in lock or configuration area give transfer error.
// - Lock bits of unprotected bytes read zero and ignore writes.
// - Lowest lock bit of a 16 or 32-bit unit is copied across it.
// - Mirror reads leave lock bits unchanged.
// - Reset clears lock bits and hard lock; supervisor writes only.
module rpw_top (
    input wire logic CLOCK,
    input wire logic RSTN,
    input wire logic BUS_SEL,
    input wire logic BUS_WR,
    input wire logic [13:0] BUS_ADDR,
    input wire logic [3:0] BUS_BE,
    input wire logic [31:0] BUS_WDATA,
    input wire logic BUS_SUPV,
    output logic BUS_READY,
    output logic BUS_ERR,
    output logic [31:0] BUS_RDATA,
    output logic MOD_SEL,
    output logic MOD_WR,
    output logic [12:0] MOD_ADDR,
    output logic [3:0] MOD_BE,
    output logic [31:0] MOD_WDATA,
    input wire logic MOD_READY,
    input wire logic MOD_ERR,
    input wire logic [31:0] MOD_RDATA,
    output logic HARD_LOCK,
    output logic USER_ACCESS
);

    rpw_lock_if lk ();

    rpw_lock_store u_store (
        .clk(CLOCK),
        .rst_n(RSTN),
        .lk(lk.store)
    );

    rpw_pkg::rpw_state_e state;
    rpw_pkg::rpw_state_e next_state;
    rpw_pkg::rpw_area_e area;
    logic [13:0] r_addr;
    logic r_wr;
    logic [3:0] r_be;
    logic [31:0] r_wdata;
    logic r_supv;
    logic to_mod;
    logic locked;
    logic unimpl;
    logic deny_mode;
    logic deny_lock;
    logic deny_hard;
    logic deny;
    logic forward;
    logic mirror_wr;
    logic [15:0] lk_we;
    logic [15:0] lk_val;
    logic [3:0] mset;
    logic [31:0] local_rdata;

    // Area decode of a window offset
    function automatic rpw_pkg::rpw_area_e area_of(input logic [13:0] a);
        if (a < `RPW_RSVD_BASE) begin
            area_of = rpw_pkg::AR_PASS;
        end else if (a < `RPW_MIRROR_BASE) begin
            area_of = rpw_pkg::AR_RSVD;
        end else if (a <= `RPW_MIRROR_END) begin
            area_of = rpw_pkg::AR_MIRROR;
        end else if (a <= `RPW_LOCK_END) begin
            area_of = rpw_pkg::AR_LOCK;
        end else begin
            area_of = rpw_pkg::AR_CFG;
        end
    endfunction

    // Lock bits that physically exist for a protection unit
    function automatic logic [3:0] prot_mask(input rpw_pkg::rpw_psize_e ps);
        prot_mask = (ps == rpw_pkg::PS_NONE) ? 4'h0 : 4'hf;
    endfunction

    // Enable and value after copying the unit's lowest bit across the unit
    function automatic logic [7:0] spread(input rpw_pkg::rpw_psize_e ps,
                                          input logic [3:0] we, input logic [3:0] val);
        case (ps)
            rpw_pkg::PS_32: spread = {{4{we[0]}}, {4{val[0]}}};
            rpw_pkg::PS_16: spread = {{2{we[2]}}, {2{we[0]}}, {2{val[2]}}, {2{val[0]}}};
            rpw_pkg::PS_8: spread = {we, val};
            default: spread = 8'h00;
        endcase
    endfunction

    // Lock bits a mirror write sets: a touched unit locks whole
    function automatic logic [3:0] touch(input rpw_pkg::rpw_psize_e ps,
                                         input logic [3:0] be);
        case (ps)
            rpw_pkg::PS_32: touch = {4{|be}};
            rpw_pkg::PS_16: touch = {{2{|be[3:2]}}, {2{|be[1:0]}}};
            rpw_pkg::PS_8: touch = be;
            default: touch = 4'h0;
        endcase
    endfunction

    // Area decode and lock store lookups, kept apart from the checks that read them back
    assign area = area_of(r_addr);
    assign lk.chk_reg = ((area == rpw_pkg::AR_PASS) || (area == rpw_pkg::AR_MIRROR)) ?
                        r_addr[12:2] : 11'h0;
    assign lk.rd_word = (area == rpw_pkg::AR_LOCK) ? r_addr[10:2] : 9'h0;

    // Access classification and error checks on the latched request
    always_comb begin
        logic [3:0] pm;
        logic [7:0] sp;
        logic [7:0] by;
        logic any_impl;
        pm = 4'h0;
        sp = 8'h00;
        by = 8'h00;
        any_impl = 1'b0;
        to_mod = (area == rpw_pkg::AR_PASS) || (area == rpw_pkg::AR_RSVD) ||
                 (area == rpw_pkg::AR_MIRROR);
        locked = ((area == rpw_pkg::AR_PASS) || (area == rpw_pkg::AR_MIRROR)) &&
                 (|(lk.chk_bits & r_be));
        lk_we = 16'h0;
        lk_val = 16'h0;
        local_rdata = 32'h0;
        for (int l = 0; l < 4; l++) begin
            pm = prot_mask(rpw_pkg::prot_size({r_addr[10:2], 2'(l)}));
            any_impl = any_impl | (|pm);
            by = r_wdata[8*l +: 8];
            sp = spread(rpw_pkg::prot_size({r_addr[10:2], 2'(l)}),
                        r_be[l] ? by[`RPW_WE_LSB +: 4] : 4'h0,
                        by[`RPW_SLB_LSB +: 4]);
            lk_we[4*l +: 4] = sp[7:4] & pm;
            lk_val[4*l +: 4] = sp[3:0];
            local_rdata[8*l +: 8] = {4'h0, lk.rd_bits[4*l +: 4] & pm};
        end
        unimpl = 1'b0;
        if (area == rpw_pkg::AR_LOCK) begin
            unimpl = !any_impl;
        end else if (area == rpw_pkg::AR_CFG) begin
            unimpl = (r_addr[13:2] != `RPW_GCR_OFS >> 2);
            local_rdata = 32'h0;
            local_rdata[`RPW_GCR_HLB_BIT] = HARD_LOCK;
            local_rdata[`RPW_GCR_UAA_BIT] = USER_ACCESS;
        end
        // Mode check is added on top of whatever the module itself refuses
        deny_mode = r_wr && !r_supv && (to_mod ? !USER_ACCESS : 1'b1);
        deny_lock = r_wr && locked;
        deny_hard = r_wr && (area == rpw_pkg::AR_LOCK) && HARD_LOCK;
        deny = unimpl || deny_mode || deny_lock || deny_hard;
        forward = to_mod && !deny;
        mirror_wr = (area == rpw_pkg::AR_MIRROR) && r_wr;
        mset = touch(rpw_pkg::prot_size(r_addr[12:2]), r_be) &
               prot_mask(rpw_pkg::prot_size(r_addr[12:2]));
    end

    // Lock store writes: direct lock-area write or mirror side effect
    always_comb begin
        lk.wr_en = 1'b0;
        lk.wr_word = 9'h0;
        lk.wr_we = 16'h0;
        lk.wr_val = 16'h0;
        if (!HARD_LOCK) begin
            if (state == rpw_pkg::ST_CHECK && area == rpw_pkg::AR_LOCK && r_wr && !deny) begin
                lk.wr_en = 1'b1;
                lk.wr_word = r_addr[10:2];
                lk.wr_we = lk_we;
                lk.wr_val = lk_val;
            end else if (state == rpw_pkg::ST_WAIT && mirror_wr && MOD_READY && !MOD_ERR) begin
                lk.wr_en = 1'b1;
                lk.wr_word = r_addr[12:4];
                lk.wr_we = {12'h0, mset} << {r_addr[3:2], 2'b00};
                lk.wr_val = lk.wr_we;
            end
        end
    end

    // Sequencer next state
    always_comb begin
        next_state = state;
        case (state)
            rpw_pkg::ST_IDLE: begin
                if (BUS_SEL) begin
                    next_state = rpw_pkg::ST_CHECK;
                end
            end
            rpw_pkg::ST_CHECK: begin
                next_state = forward ? rpw_pkg::ST_WAIT : rpw_pkg::ST_RESP;
            end
            rpw_pkg::ST_WAIT: begin
                if (MOD_READY) begin
                    next_state = rpw_pkg::ST_RESP;
                end
            end
            default: next_state = rpw_pkg::ST_IDLE;
        endcase
    end

    // Sequencer state
    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            state <= rpw_pkg::ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Request capture when idle
    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            r_addr <= 14'h0;
            r_wr <= 1'b0;
            r_be <= 4'h0;
            r_wdata <= 32'h0;
            r_supv <= 1'b0;
        end else if (state == rpw_pkg::ST_IDLE && BUS_SEL) begin
            r_addr <= BUS_ADDR;
            r_wr <= BUS_WR;
            r_be <= BUS_BE;
            r_wdata <= BUS_WDATA;
            r_supv <= BUS_SUPV;
        end
    end

    // Protected module request, mirror offset folded onto the base register
    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            MOD_SEL <= 1'b0;
            MOD_WR <= 1'b0;
            MOD_ADDR <= 13'h0;
            MOD_BE <= 4'h0;
            MOD_WDATA <= 32'h0;
        end else if (state == rpw_pkg::ST_CHECK && forward) begin
            MOD_SEL <= 1'b1;
            MOD_WR <= r_wr;
            MOD_ADDR <= r_addr[12:0];
            MOD_BE <= r_be;
            MOD_WDATA <= r_wdata;
        end else if (state == rpw_pkg::ST_WAIT && MOD_READY) begin
            MOD_SEL <= 1'b0;
        end
    end

    // Bus answer: one-cycle ready, error and data stand until the next answer
    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            BUS_READY <= 1'b0;
            BUS_ERR <= 1'b0;
            BUS_RDATA <= 32'h0;
        end else if (state == rpw_pkg::ST_CHECK && !forward) begin
            BUS_READY <= 1'b1;
            BUS_ERR <= deny;
            BUS_RDATA <= (deny || r_wr || to_mod) ? 32'h0 : local_rdata;
        end else if (state == rpw_pkg::ST_WAIT && MOD_READY) begin
            BUS_READY <= 1'b1;
            BUS_ERR <= MOD_ERR;
            BUS_RDATA <= r_wr ? 32'h0 : MOD_RDATA;
        end else begin
            BUS_READY <= 1'b0;
        end
    end

    // Global configuration word; hard lock is set-only
    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            HARD_LOCK <= `RPW_HLB_RST;
            USER_ACCESS <= `RPW_UAA_RST;
        end else if (state == rpw_pkg::ST_CHECK && area == rpw_pkg::AR_CFG && r_wr && !deny) begin
            if (r_be[3] && r_wdata[`RPW_GCR_HLB_BIT]) begin
                HARD_LOCK <= 1'b1;
            end
            if (r_be[0]) begin
                USER_ACCESS <= r_wdata[`RPW_GCR_UAA_BIT];
            end
        end
    end

    // Checks
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!RSTN);

    pass_route_a: assert property ((state == rpw_pkg::ST_CHECK && forward) |=>
        MOD_SEL && MOD_WR == $past(r_wr) && MOD_BE == $past(r_be))
        else $error("forwarded request not presented to module");

    mirror_fold_a: assert property ((state == rpw_pkg::ST_CHECK && forward
        && area == rpw_pkg::AR_MIRROR) |=> MOD_ADDR == $past(r_addr[12:0]) && MOD_SEL)
        else $error("mirror address not folded");

    mirror_lock_a: assert property ((state == rpw_pkg::ST_WAIT && mirror_wr
        && MOD_READY && !MOD_ERR && !HARD_LOCK && |mset) |-> lk.wr_en ##1 BUS_READY)
        else $error("mirror write did not set lock bits");

    locked_block_a: assert property ((state == rpw_pkg::ST_CHECK && r_wr && locked)
        |=> BUS_READY && BUS_ERR && !MOD_SEL)
        else $error("write to locked byte not refused");

    hard_frozen_a: assert property (HARD_LOCK |-> !lk.wr_en)
        else $error("lock bits changed under hard lock");

    hard_sticky_a: assert property (HARD_LOCK |=> HARD_LOCK)
        else $error("hard lock cleared without reset");

    user_block_a: assert property ((state == rpw_pkg::ST_CHECK && r_wr && !r_supv
        && !USER_ACCESS) |=> BUS_ERR && BUS_READY && !MOD_SEL)
        else $error("user write not refused");

    unimpl_err_a: assert property ((state == rpw_pkg::ST_CHECK && unimpl)
        |=> BUS_READY && BUS_ERR)
        else $error("unimplemented word did not error");

    read_nolock_a: assert property ((state == rpw_pkg::ST_WAIT && !r_wr) |-> !lk.wr_en)
        else $error("read changed lock bits");

    reset_state_a: assert property ($rose(RSTN) |-> !HARD_LOCK && !USER_ACCESS)
        else $error("configuration not cleared by reset");

    ready_pulse_a: assert property (BUS_READY |=> !BUS_READY && state == rpw_pkg::ST_IDLE)
        else $error("answer longer than one cycle");

    mirror_done_c: cover property (state == rpw_pkg::ST_WAIT && mirror_wr && lk.wr_en);
    lock_write_c: cover property (state == rpw_pkg::ST_CHECK && area == rpw_pkg::AR_LOCK
        && lk.wr_en);
    hard_set_c: cover property ($rose(HARD_LOCK));
    refused_c: cover property (BUS_READY && BUS_ERR);

endmodule

// ---- bench/rpw_mod_model.sv ----
`timescale 1ns/100ps

// Protected module stand-in: word store, answer after dly idle cycles
module rpw_mod_model (
    input wire logic clk,
    input wire logic sel,
    input wire logic wr,
    input wire logic [12:0] addr,
    input wire logic [3:0] be,
    input wire logic [31:0] wdata,
    input wire logic [1:0] dly,
    output logic ready,
    output logic err,
    output logic [31:0] rdata
);
    logic [31:0] mem [0:2047];
    logic [1:0] cnt = 2'h0;
    logic [31:0] last = 32'h0;
    logic refuse;

    // The module's own refusal: its upper 2 KB answers with an error
    assign refuse = (addr[12:11] == 2'h3);

    // One-cycle answer; read data is scrambled outside the answer cycle
    always @(posedge clk) begin
        ready <= 1'b0;
        err <= 1'b0;
        rdata <= ~last;
        if (sel && !ready) begin
            cnt <= cnt + 2'h1;
            if (cnt == dly) begin
                cnt <= 2'h0;
                ready <= 1'b1;
                err <= refuse;
                rdata <= refuse ? 32'h0 : mem[addr[12:2]];
                last <= mem[addr[12:2]];
            end
        end
        // Write commits at the edge that ends the answer cycle, with the lock update
        if (sel && ready && wr && !err) begin
            for (int i = 0; i < 4; i++) begin
                if (be[i]) begin
                    mem[addr[12:2]][8*i+:8] <= wdata[8*i+:8];
                end
            end
        end
    end
endmodule

// ---- bench/rpw_top_tb_top.sv ----
`timescale 1ns/100ps

module rpw_top_tb_top;
    logic CLOCK = 1'b0;
    logic RSTN = 1'b0;
    logic BUS_SEL = 1'b0;
    logic BUS_WR = 1'b0;
    logic [13:0] BUS_ADDR = 14'h0;
    logic [3:0] BUS_BE = 4'h0;
    logic [31:0] BUS_WDATA = 32'h0;
    logic BUS_SUPV = 1'b1;
    logic BUS_READY, BUS_ERR, MOD_SEL, MOD_WR, MOD_READY, MOD_ERR, HARD_LOCK, USER_ACCESS;
    logic [31:0] BUS_RDATA, MOD_WDATA, MOD_RDATA;
    logic [12:0] MOD_ADDR;
    logic [3:0] MOD_BE;
    logic [1:0] dly = 2'h2;
    int error_cnt = 0;
    int check_count = 0;
    logic [31:0] rd_v;
    logic err_v;

    rpw_top dut_u (.CLOCK(CLOCK), .RSTN(RSTN), .BUS_SEL(BUS_SEL), .BUS_WR(BUS_WR),
        .BUS_ADDR(BUS_ADDR), .BUS_BE(BUS_BE), .BUS_WDATA(BUS_WDATA), .BUS_SUPV(BUS_SUPV),
        .BUS_READY(BUS_READY), .BUS_ERR(BUS_ERR), .BUS_RDATA(BUS_RDATA), .MOD_SEL(MOD_SEL),
        .MOD_WR(MOD_WR), .MOD_ADDR(MOD_ADDR), .MOD_BE(MOD_BE), .MOD_WDATA(MOD_WDATA),
        .MOD_READY(MOD_READY), .MOD_ERR(MOD_ERR), .MOD_RDATA(MOD_RDATA),
        .HARD_LOCK(HARD_LOCK), .USER_ACCESS(USER_ACCESS));

    rpw_mod_model mod_u (.clk(CLOCK), .sel(MOD_SEL), .wr(MOD_WR), .addr(MOD_ADDR),
        .be(MOD_BE), .wdata(MOD_WDATA), .dly(dly), .ready(MOD_READY), .err(MOD_ERR),
        .rdata(MOD_RDATA));

    // 20 MHz bus clock
    initial begin
        forever #25 CLOCK = ~CLOCK;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Bridge cycle: request held until READY is seen at a falling edge, released at the next rising edge
    task automatic xfer(input logic w, input logic [13:0] a, input logic [3:0] be,
        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge CLOCK);
        BUS_SEL <= 1'b1;
        BUS_WR <= w;
        BUS_ADDR <= a;
        BUS_BE <= be;
        BUS_WDATA <= d;
        @(negedge CLOCK);
        while (BUS_READY !== 1'b1) begin
            n++;
            if (n > 40) begin
                error_cnt++;
                end_of_test();
            end
            @(negedge CLOCK);
        end
        rd_v = BUS_RDATA;
        err_v = BUS_ERR;
        @(posedge CLOCK);
        BUS_SEL <= 1'b0;
    endtask

    task automatic wchk(input logic [13:0] a, input logic [3:0] be, input logic [31:0] d,
        input logic e);
        xfer(1'b1, a, be, d);
        chk({31'h0, err_v}, {31'h0, e});
    endtask

    task automatic rchk(input logic [13:0] a, input logic [31:0] exp, input logic e);
        xfer(1'b0, a, 4'hf, 32'h0);
        chk({31'h0, err_v}, {31'h0, e});
        chk(rd_v, exp);
    endtask

    task automatic do_reset;
        RSTN <= 1'b0;
        repeat (10) @(posedge CLOCK);
        RSTN <= 1'b1;
        repeat (2) @(posedge CLOCK);
    endtask

    task automatic t_reset;
        chk({31'h0, HARD_LOCK}, 32'h0);
        chk({31'h0, USER_ACCESS}, 32'h0);
        rchk(14'h3ffc, 32'h0, 1'b0);
        rchk(14'h3800, 32'h0, 1'b0);
        $display("reset test done");
    endtask

    task automatic t_pass;
        wchk(14'h0010, 4'hf, 32'h1234abcd, 1'b0);
        wchk(14'h0010, 4'h2, 32'h0000ee00, 1'b0);
        rchk(14'h0010, 32'h1234eecd, 1'b0);
        rchk(14'h2010, 32'h1234eecd, 1'b0);
        rchk(14'h3804, 32'h0, 1'b0);
        wchk(14'h0008, 4'hf, 32'haabbccdd, 1'b0);
        $display("pass-through test done");
    endtask

    task automatic t_user;
        BUS_SUPV <= 1'b0;
        wchk(14'h0010, 4'hf, 32'h0, 1'b1);
        rchk(14'h0010, 32'h1234eecd, 1'b0);
        BUS_SUPV <= 1'b1;
        wchk(14'h3ffc, 4'hf, 32'h7fffffff, 1'b0);
        rchk(14'h3ffc, 32'h1, 1'b0);
        chk({31'h0, USER_ACCESS}, 32'h1);
        BUS_SUPV <= 1'b0;
        wchk(14'h0010, 4'hf, 32'h55, 1'b0);
        rchk(14'h0010, 32'h55, 1'b0);
        wchk(14'h3800, 4'hf, 32'h11, 1'b1);
        BUS_SUPV <= 1'b1;
        wchk(14'h3ffc, 4'hf, 32'h0, 1'b0);
        chk({31'h0, USER_ACCESS}, 32'h0);
        $display("user mode test done");
    endtask

    task automatic t_lockreg;
        wchk(14'h3800, 4'hf, 32'hff234411, 1'b0);
        rchk(14'h3800, 32'h00020c0f, 1'b0);
        wchk(14'h3800, 4'hf, 32'h0e0e0e0e, 1'b0);
        rchk(14'h3800, 32'h00020c0f, 1'b0);
        $display("lock register test done");
    endtask

    task automatic t_locked;
        wchk(14'h0008, 4'h3, 32'h11223344, 1'b1);
        rchk(14'h0008, 32'haabbccdd, 1'b0);
        wchk(14'h0008, 4'h4, 32'h00ee0000, 1'b0);
        rchk(14'h0008, 32'haaeeccdd, 1'b0);
        wchk(14'h0004, 4'h3, 32'h1, 1'b0);
        wchk(14'h0004, 4'h8, 32'h0, 1'b1);
        wchk(14'h0000, 4'h1, 32'h0, 1'b1);
        wchk(14'h2000, 4'h1, 32'h0, 1'b1);
        $display("locked write test done");
    endtask

    task automatic t_mirror;
        dly <= 2'h0;
        wchk(14'h0014, 4'hf, 32'h0, 1'b0);
        wchk(14'h2014, 4'h1, 32'h5a, 1'b0);
        rchk(14'h0014, 32'h5a, 1'b0);
        rchk(14'h3804, 32'h00000300, 1'b0);
        wchk(14'h0014, 4'h1, 32'h0, 1'b1);
        wchk(14'h2018, 4'h2, 32'h0, 1'b0);
        wchk(14'h201c, 4'hf, 32'h77, 1'b0);
        rchk(14'h3804, 32'h00020300, 1'b0);
        wchk(14'h2020, 4'h2, 32'h0, 1'b0);
        rchk(14'h3808, 32'h0000000f, 1'b0);
        wchk(14'h001c, 4'hf, 32'h78, 1'b0);
        $display("mirror test done");
    endtask

    task automatic t_cfg;
        dly <= 2'h1;
        rchk(14'h3e00, 32'h0, 1'b1);
        rchk(14'h3ff8, 32'h0, 1'b1);
        wchk(14'h3e00, 4'hf, 32'h0, 1'b1);
        rchk(14'h1800, 32'h0, 1'b1);
        wchk(14'h1804, 4'hf, 32'h1, 1'b1);
        $display("config and reserved test done");
    endtask

    task automatic t_hard;
        wchk(14'h3ffc, 4'h8, 32'h80000000, 1'b0);
        chk({31'h0, HARD_LOCK}, 32'h1);
        wchk(14'h3800, 4'hf, 32'h000000f0, 1'b1);
        rchk(14'h3800, 32'h00020c0f, 1'b0);
        wchk(14'h3ffc, 4'hf, 32'h0, 1'b0);
        chk({31'h0, HARD_LOCK}, 32'h1);
        wchk(14'h2028, 4'h4, 32'h0, 1'b0);
        rchk(14'h3808, 32'h0000000f, 1'b0);
        do_reset();
        chk({31'h0, HARD_LOCK}, 32'h0);
        rchk(14'h3800, 32'h0, 1'b0);
        $display("hard lock test done");
    endtask

    // Main sequence
    initial begin
        do_reset();
        t_reset();
        t_pass();
        t_user();
        t_lockreg();
        t_locked();
        t_mirror();
        t_cfg();
        t_hard();
        end_of_test();
    end
endmodule
